/* hdl/wdt_pkg.sv */
// Constants, register map and state type for the malfunction watchdog
// Assumes clk_i is the fast clock and all users import the whole package
//
// What this block does
// RULE1: Watchdog runs straight after reset release with no software action.
// RULE2: Overflow action defaults to reset request after reset release.
// RULE3: Once action is cleared to interrupt, it cannot be set again until reset.
// RULE4: Overflow with action 1 requests reset, drives reset pin low, reinitialises.
// RULE5: Overflow with action 0 raises the watchdog interrupt instead.
// RULE6: Count freezes in stop, warm-up, idle and sleep; resumes from held value. There is no warm-up input: only stop, idle and sleep freeze.
// RULE7: Divider plus two-stage binary counter; clear code resets only the binary stage.
// RULE8: Software must rewrite clear code within three quarters of the period.
// RULE9: Two-bit period field selects fast or slow clock overflow period.
// RULE10: First control register is write-only; reads give undefined data.
// RULE11: Disable code takes effect only while the enable bit already holds 0.
// RULE12: Software sets period and action, clears, then keeps clearing in time.
// RULE13: Software writes clear code just before and after changing the period.
// RULE14: Software disables or clears before stop mode, clears again after it.
// RULE15: Software must not clear the binary counter from an interrupt task.
// RULE16: Watchdog may serve as a periodic interrupt at every overflow.
// RULE17: Disable order: master flag off, clear code, enable 0, disable code.
// RULE18: While disabled, the binary counters are held cleared.
// RULE19: Watchdog reset holds pin and internal reset low at most 24 fast clocks; here internal_reset_o is driven high for those clocks.
// RULE20: Watchdog interrupt is non-maskable, ignores the interrupt master flag.
// RULE21: Code register writes of other values change nothing.

package wdt_pkg;

   // ----------------------------------------
   // Bus and register map
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [7:0] IDX_CONTROL_ONE = 8'h34;
   localparam logic [7:0] IDX_GUARD_CODE = 8'h35;
   localparam logic [7:0] IDX_CONFIG = 8'h38;
   localparam logic [7:0] IDX_STATUS = 8'h39;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE = {2'h0, IDX_CONTROL_ONE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_GUARD_CODE = {2'h0, IDX_GUARD_CODE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int CTL_OUT_BIT = 0;
   localparam int CTL_PER_LSB = 1;
   localparam int CTL_PER_MSB = 2;
   localparam int CTL_EN_BIT = 3;
   localparam int CFG_PRESCALE_BIT = 0;
   localparam logic EN_RST = 1'h1;
   localparam logic [1:0] PER_RST = 2'h0;
   localparam logic OUT_RST = 1'h1;
   localparam logic PRESCALE_RST = 1'h0;
   localparam logic [7:0] CODE_CLEAR = 8'h4e;
   localparam logic [7:0] CODE_DISABLE = 8'hb1;

   // ----------------------------------------
   // Counter geometry and timing
   // ----------------------------------------
   localparam int DIV_W = 23;
   localparam int TAP_W = 5;
   localparam int FAST_QUARTER_LOG2_DEF = 23;
   localparam int SLOW_QUARTER_LOG2_DEF = 15;
   localparam int PERIOD_STEP_LOG2 = 2;
   localparam logic [1:0] BIN_LAST = 2'h3;
   localparam int CLK_HZ = 10_000_000;
   localparam int FAST_CLOCK_FREQ = CLK_HZ;
   localparam int RESET_HOLD_FAST = 24;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_FAST * CLK_HZ) / FAST_CLOCK_FREQ;
   localparam int HOLD_W = 5;
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYCLES - 1);

   typedef enum logic [1:0] {GUARD_ON, GUARD_OFF, GUARD_RESET} guard_state_t;

endpackage

/* hdl/wdt_tick_if.sv */
// Carrier between the watchdog top and its divider
// Assumes both ends run on the same clock
`timescale 1ns/10ps
interface wdt_tick_if;
   import wdt_pkg::*;
   logic tick;
   logic [TAP_W-1:0] tap_log2;
   logic step;
   modport src (output tick, output tap_log2, input step);
   modport div (input tick, input tap_log2, output step);
endinterface

/* hdl/wdt_divider.sv */
// Free-running watchdog divider with selectable tap
// Assumes tick is a one-cycle enable from the top, already gated by freeze
`timescale 1ns/10ps
module wdt_divider
   import wdt_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   wdt_tick_if.div bus
);

   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;
   logic [DIV_W-1:0] tap_mask;

   // Never cleared by the clear code, so the first step after a clear comes early
   assign tap_mask = ~({DIV_W{1'h1}} << bus.tap_log2);
   assign bus.step = bus.tick & ((div_reg & tap_mask) == tap_mask); // RULE7
   assign div_next = bus.tick ? div_reg + 1'h1 : div_reg; // RULE6

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   a_step_tap_align: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE9
      bus.step |=> ((div_reg & tap_mask) == '0) || !$stable(bus.tap_log2))
      else $error("divider step not aligned to selected tap");

   a_frozen_div: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
      !bus.tick |=> $stable(div_reg))
      else $error("divider moved without a tick");

endmodule

/* hdl/malfunction_watchdog_timer.sv */
// Malfunction watchdog: APB registers, guard state, binary stage, reset pulse
// Assumes an APB master on clk_i and mode inputs synchronous to clk_i
`timescale 1ns/10ps
module malfunction_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int FAST_QUARTER_LOG2 = FAST_QUARTER_LOG2_DEF,
   parameter int SLOW_QUARTER_LOG2 = SLOW_QUARTER_LOG2_DEF
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic slow_tick_i,
   input wire logic slow_mode_i,
   input wire logic stop_mode_i,
   input wire logic idle_mode_i,
   input wire logic sleep_mode_i,
   output logic reset_pin_n_o,
   output logic internal_reset_o,
   output logic guard_interrupt_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Each period code step divides the quarter period by four
   function automatic logic [TAP_W-1:0] tap_of(input int quarter_log2,
                                                input logic [1:0] sel);
      int t;
      t = quarter_log2 - PERIOD_STEP_LOG2 * int'(sel);
      return TAP_W'(t);
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------

   logic pready_reg;
   logic pready_next;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;

   logic enable_bit_reg;
   logic enable_bit_next;
   logic [1:0] period_reg;
   logic [1:0] period_next;
   logic action_reg;
   logic action_next;
   logic prescale_reg;
   logic prescale_next;

   guard_state_t state_reg;
   guard_state_t state_next;
   logic [1:0] bin_reg;
   logic [1:0] bin_next;
   logic [HOLD_W-1:0] hold_reg;
   logic [HOLD_W-1:0] hold_next;
   logic pin_n_reg;
   logic pin_n_next;
   logic irq_reg;
   logic irq_next;
   logic int_rst_reg;
   logic int_rst_next;

   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic hit_ctl;
   logic hit_code;
   logic hit_cfg;
   logic hit_sta;
   logic mapped;
   logic [7:0] wdata_b;
   logic ctl_wr;
   logic code_wr;
   logic cfg_wr;
   logic clear_hit;
   logic disable_hit;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] config_word;
   logic [DATA_W-1:0] rdata_sel;

   logic running;
   logic freeze;
   logic use_slow;
   logic overflow;
   logic init_now;

   wdt_tick_if tick_bus ();

   // ----------------------------------------
   // APB decode
   // ----------------------------------------

   assign setup_phase = psel_i & ~penable_i;
   assign access_done = psel_i & penable_i & pready_reg;
   assign wr_done = access_done & pwrite_i;
   assign hit_ctl = (paddr_i == ADDR_CONTROL_ONE);
   assign hit_code = (paddr_i == ADDR_GUARD_CODE);
   assign hit_cfg = (paddr_i == ADDR_CONFIG);
   assign hit_sta = (paddr_i == ADDR_STATUS);
   assign mapped = hit_ctl | hit_code | hit_cfg | hit_sta;
   assign wdata_b = pwdata_i[7:0];
   assign ctl_wr = wr_done & hit_ctl;
   assign code_wr = wr_done & hit_code;
   assign cfg_wr = wr_done & hit_cfg;
   assign clear_hit = code_wr & (wdata_b == CODE_CLEAR); // RULE7
   assign disable_hit = code_wr & (wdata_b == CODE_DISABLE);

   assign status_word = {{(DATA_W-8){1'h0}}, prescale_reg, ~pin_n_reg, bin_reg,
                         period_reg, action_reg, running};
   assign config_word = {{(DATA_W-1){1'h0}}, prescale_reg};

   // Control and code registers are write-only and read as zero
   assign rdata_sel = hit_sta ? status_word :
                      hit_cfg ? config_word : '0; // RULE10

   // One registered answer per transfer: data and error are settled in setup
   assign pready_next = setup_phase;
   assign prdata_next = (setup_phase & ~pwrite_i) ? rdata_sel : '0;
   assign pslverr_next = setup_phase & ~mapped;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_reg <= 1'h0;
         prdata_reg <= '0;
         pslverr_reg <= 1'h0;
      end else begin
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------

   assign init_now = overflow & action_reg; // RULE4

   assign enable_bit_next = init_now ? EN_RST :
                            ctl_wr ? wdata_b[CTL_EN_BIT] : enable_bit_reg;
   assign period_next = init_now ? PER_RST :
                        ctl_wr ? wdata_b[CTL_PER_MSB:CTL_PER_LSB] : period_reg;
   // Software may only clear the action select, never set it
   assign action_next = init_now ? OUT_RST :
                        ctl_wr ? (action_reg & wdata_b[CTL_OUT_BIT]) : action_reg; // RULE3
   assign prescale_next = cfg_wr ? wdata_b[CFG_PRESCALE_BIT] : prescale_reg;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_bit_reg <= EN_RST; // RULE1
         period_reg <= PER_RST;
         action_reg <= OUT_RST; // RULE2
         prescale_reg <= PRESCALE_RST;
      end else begin
         enable_bit_reg <= enable_bit_next;
         period_reg <= period_next;
         action_reg <= action_next;
         prescale_reg <= prescale_next;
      end
   end

   // ----------------------------------------
   // Clock source and divider
   // ----------------------------------------

   assign freeze = stop_mode_i | idle_mode_i | sleep_mode_i;
   assign use_slow = slow_mode_i | prescale_reg;
   assign tick_bus.tick = ~freeze & (use_slow ? slow_tick_i : 1'h1); // RULE6
   assign tick_bus.tap_log2 = use_slow ? tap_of(SLOW_QUARTER_LOG2, period_reg) :
                                         tap_of(FAST_QUARTER_LOG2, period_reg); // RULE9

   wdt_divider u_divider (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .bus(tick_bus.div)
   );

   // ----------------------------------------
   // Guard state and binary stage
   // ----------------------------------------

   assign running = (state_reg == GUARD_ON);
   // Clear code in the same cycle as the last step wins, so no overflow
   assign overflow = running & tick_bus.step & (bin_reg == BIN_LAST) & ~clear_hit;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         GUARD_ON: begin
            if (init_now) begin
               state_next = GUARD_RESET;
            end else if (disable_hit & ~enable_bit_reg) begin
               state_next = GUARD_OFF; // RULE11
            end
         end
         GUARD_OFF: begin
            if (ctl_wr & wdata_b[CTL_EN_BIT]) begin
               state_next = GUARD_ON;
            end
         end
         GUARD_RESET: begin
            if (hold_reg == HOLD_LAST) begin
               state_next = GUARD_ON; // RULE19
            end
         end
         default: begin
            state_next = GUARD_ON;
         end
      endcase
   end

   // Unknown codes fall through every branch and leave the stage alone
   assign bin_next = !running ? 2'h0 : // RULE18
                     clear_hit ? 2'h0 : // RULE7
                     tick_bus.step ? bin_reg + 2'h1 : bin_reg; // RULE21

   assign hold_next = (state_reg == GUARD_RESET) ? hold_reg + 1'h1 : '0;
   assign pin_n_next = (state_next != GUARD_RESET); // RULE4
   // Own flop so the internal reset leaves a register, not an inverter
   assign int_rst_next = ~pin_n_next; // RULE4
   // Pulse, no mask: the counter wraps and keeps firing for periodic use
   assign irq_next = overflow & ~action_reg; // RULE5 RULE16 RULE20

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= GUARD_ON; // RULE1
         bin_reg <= 2'h0;
         hold_reg <= '0;
         pin_n_reg <= 1'h1;
         irq_reg <= 1'h0;
         int_rst_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         bin_reg <= bin_next;
         hold_reg <= hold_next;
         pin_n_reg <= pin_n_next;
         irq_reg <= irq_next;
         int_rst_reg <= int_rst_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign reset_pin_n_o = pin_n_reg;
   assign internal_reset_o = int_rst_reg;
   assign guard_interrupt_o = irq_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   int low_run;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_run <= 0;
      end else begin
         low_run <= reset_pin_n_o ? 0 : low_run + 1;
      end
   end

   a_boot_defaults: assert property ( // RULE1
      !$past(resetn_i) |-> running && action_reg)
      else $error("watchdog not running with reset action after reset");

   a_action_sticky: assert property ( // RULE3
      (!action_reg && !init_now) |=> !action_reg)
      else $error("action select returned to reset without a reset");

   a_reset_on_over: assert property ( // RULE4
      (overflow && action_reg) |=> !reset_pin_n_o && internal_reset_o && !running)
      else $error("overflow with reset action did not pull reset low");

   a_irq_on_over: assert property ( // RULE5
      (overflow && !action_reg) |=> guard_interrupt_o && reset_pin_n_o ##1 !guard_interrupt_o)
      else $error("overflow with interrupt action gave no single interrupt");

   a_freeze_hold: assert property ( // RULE6
      (freeze && !code_wr && running) |=> $stable(bin_reg))
      else $error("binary stage moved while frozen");

   a_clear_code: assert property ( // RULE7
      clear_hit |=> (bin_reg == 2'h0) && !guard_interrupt_o)
      else $error("clear code did not clear the binary stage");

   a_disable_gate: assert property ( // RULE11
      (disable_hit && enable_bit_reg && running) |=> running)
      else $error("disable code accepted while enable bit set");

   a_off_cleared: assert property ( // RULE18
      (state_reg == GUARD_OFF) ##1 (state_reg == GUARD_OFF) |-> bin_reg == 2'h0)
      else $error("binary stage not held clear while disabled");

   a_reset_width: assert property ( // RULE19
      low_run <= RESET_HOLD_CYCLES)
      else $error("watchdog reset held longer than allowed");

   a_ctl_reads_zero: assert property ( // RULE10
      (setup_phase && !pwrite_i && hit_ctl) |=> prdata_o == '0)
      else $error("control register read returned data");

   a_other_codes: assert property ( // RULE21
      (code_wr && !clear_hit && !disable_hit && !overflow && state_reg != GUARD_RESET) |=>
         $stable(state_reg) && $stable(action_reg))
      else $error("unknown code changed watchdog state");

   a_reset_pair: assert property ( // RULE4
      reset_pin_n_o == !internal_reset_o)
      else $error("reset pin and internal reset disagree");

   a_reinit_regs: assert property ( // RULE4
      init_now |=> (action_reg == OUT_RST) && (enable_bit_reg == EN_RST) && (period_reg == PER_RST))
      else $error("watchdog reset did not reinitialise control");

   a_hold_restart: assert property ( // RULE19
      (state_reg == GUARD_RESET && hold_reg == HOLD_LAST) |=> running && reset_pin_n_o)
      else $error("watchdog did not restart after reset pulse");

   a_off_silent: assert property ( // RULE18
      (state_reg == GUARD_OFF) |=> !guard_interrupt_o && reset_pin_n_o)
      else $error("disabled watchdog raised an output");

   a_irq_not_reset: assert property ( // RULE5
      guard_interrupt_o |-> reset_pin_n_o)
      else $error("interrupt and reset raised together");

endmodule

/* tb/testbench.sv */
// Self-checking bench for the malfunction watchdog: APB access, periods, actions
// Assumes the package and design files under hdl/ are compiled first
`timescale 1ns/10ps
module testbench;
   import wdt_pkg::*;

   // ----------------------------------------
   // Stimulus, monitors and instance
   // ----------------------------------------
   // Short quarter count keeps every period code inside the run budget
   localparam int QL = 7;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic slow_tick = 1'b0;
   logic slow_mode = 1'b0;
   logic [2:0] frz = 3'h0;
   logic rst_n;
   logic int_rst;
   logic irq;
   logic [1:0] sdiv = 2'h0;
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] v;
   logic err;
   int miscompares = 0;
   int n_checks = 0;
   int irq_cnt = 0;
   int lo_cnt = 0;
   int t;
   int n;
   int c0;
   int l0;

   always #50 clk = ~clk;

   // Slow source: one tick every fourth clock
   always @(posedge clk) begin
      sdiv <= sdiv + 2'h1;
      slow_tick <= (sdiv == 2'h3);
   end

   always @(negedge clk) begin
      if (irq === 1'b1) irq_cnt++;
      if (rst_n === 1'b0) lo_cnt++;
   end

   malfunction_watchdog_timer #(.FAST_QUARTER_LOG2(QL), .SLOW_QUARTER_LOG2(QL))
         malfunction_watchdog_timer_i (
      .clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .slow_tick_i(slow_tick),
      .slow_mode_i(slow_mode), .stop_mode_i(frz[0]), .idle_mode_i(frz[1]),
      .sleep_mode_i(frz[2]), .reset_pin_n_o(rst_n), .internal_reset_o(int_rst),
      .guard_interrupt_o(irq));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int w;
      w = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Read just after the edge, so this is the value that edge sampled
      do begin
         @(posedge clk);
         w++;
      end while (pready !== 1'b1 && w < 20);
      if (w >= 20) chk(1'b0, 1'b1, "no bus answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Upper data bits are random: the register takes only the low byte
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'($urandom), d});
   endtask

   task automatic wait_irq(output int c);
      int k;
      k = irq_cnt;
      c = 0;
      while (irq_cnt == k && c < 5000) begin
         @(posedge clk);
         c++;
      end
   endtask

   function automatic int exp_gap(input int p, input logic slow);
      return (4 << (QL - 2 * p)) * (slow ? 4 : 1);
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(100_000 * 100);
      miscompares++;
      close_out();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(88));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd & 32'hcf, 32'h03, "status after reset");
      apb(1'b0, ADDR_CONTROL_ONE, '0);
      chk(rd, 32'h0, "control readback");
      apb(1'b0, 12'hf00, '0);
      chk(err, 1'b1, "unmapped error");
      wreg(ADDR_CONFIG, 8'h01);
      apb(1'b0, ADDR_CONFIG, '0);
      chk(rd, 32'h1, "config readback");
      wreg(ADDR_CONFIG, 8'h00);
      $display("test power_on done");

      l0 = lo_cnt;
      wreg(ADDR_CONTROL_ONE, 8'h0f);
      n = 0;
      while (rst_n !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(int_rst, 1'b1, "internal reset");
      repeat (40) @(posedge clk);
      chk(lo_cnt - l0, 24, "reset length");
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd & 32'h4f, 32'h03, "reinit after reset");
      $display("test reset_action done");

      wreg(ADDR_CONTROL_ONE, 8'h0e);
      wreg(ADDR_CONTROL_ONE, 8'h0f);
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd[1], 1'b0, "action stays interrupt");
      l0 = lo_cnt;
      wait_irq(t);
      wait_irq(t);
      chk(t, 8, "periodic gap");
      chk(lo_cnt - l0, 0, "no reset pulse");
      $display("test interrupt_action done");

      for (int k = 0; k < 12; k++) begin
         slow_mode <= (k >= 4 && k < 8);
         wreg(ADDR_CONFIG, {7'h0, k >= 8});
         wreg(ADDR_GUARD_CODE, CODE_CLEAR);
         wreg(ADDR_CONTROL_ONE, 8'h08 | 8'((k % 4) << 1));
         wreg(ADDR_GUARD_CODE, CODE_CLEAR);
         wait_irq(t);
         wait_irq(t);
         chk(t, exp_gap(k % 4, k >= 4), "period");
      end
      slow_mode <= 1'b0;
      wreg(ADDR_CONFIG, 8'h00);
      $display("test periods done");

      wreg(ADDR_GUARD_CODE, CODE_CLEAR);
      c0 = irq_cnt;
      repeat (20) wreg(ADDR_GUARD_CODE, CODE_CLEAR);
      chk(irq_cnt - c0, 0, "clears hold off overflow");
      wait_irq(t);
      chk(t >= 6 && t <= 10, 1'b1, "first overflow after clear");
      c0 = irq_cnt;
      repeat (20) begin
         do v = $urandom; while (v[7:0] == CODE_CLEAR || v[7:0] == CODE_DISABLE);
         apb(1'b1, ADDR_GUARD_CODE, v);
      end
      chk(irq_cnt - c0 >= 6, 1'b1, "other codes ignored");
      $display("test clear_codes done");

      wreg(ADDR_GUARD_CODE, CODE_DISABLE);
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd[0], 1'b1, "disable refused while enabled");
      wreg(ADDR_GUARD_CODE, CODE_CLEAR);
      wreg(ADDR_CONTROL_ONE, 8'h00);
      wreg(ADDR_GUARD_CODE, CODE_CLEAR);
      wreg(ADDR_GUARD_CODE, CODE_DISABLE);
      c0 = irq_cnt;
      repeat (100) @(posedge clk);
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd & 32'h31, 32'h0, "stopped and cleared");
      chk(irq_cnt - c0, 0, "silent while disabled");
      wreg(ADDR_CONTROL_ONE, 8'h0e);
      $display("test disable done");

      // Idle and sleep freeze mid-count: a held count overflows sooner than a fresh one
      for (int m = 0; m < 3; m++) begin
         wreg(ADDR_GUARD_CODE, CODE_CLEAR);
         if (m > 0) repeat (4) @(posedge clk);
         frz <= 3'h1 << m;
         c0 = irq_cnt;
         repeat (100) @(posedge clk);
         chk(irq_cnt - c0, 0, "frozen");
         frz <= 3'h0;
         if (m == 0) wreg(ADDR_GUARD_CODE, CODE_CLEAR);
         wait_irq(t);
         chk(t <= ((m == 0) ? 10 : 5), 1'b1, "resumes counting");
      end
      $display("test freeze done");
      close_out();
   end
endmodule
